/* File: hdl/cmg_guard.sv */
// Purpose: Mode-based memory access guard with AHB-Lite config port
// Assumes: Core gives mode, kind and segment rights on the same clock
// Notes: Decision is registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module cmg_guard (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [2:0] bus_mode,
	input wire logic acc_valid,
	input wire logic [2:0] acc_mode,
	input wire logic [19:0] acc_addr,
	input wire logic [2:0] acc_kind,
	input wire logic acc_integrity,
	input wire logic acc_emul,
	input wire logic [2:0] acc_seg_rights,
	output logic acc_grant,
	output logic acc_deny,
	output logic [15:0] seg_table_base
);
	typedef struct packed {
		logic [15:0] seg_base;
		logic [7:0] win_bl;
		logic [7:0] win_bh;
		logic [7:0] win_sl;
		logic [7:0] win_sh;
		logic wr_pend;
		logic [7:0] wr_ofs;
		logic wr_sys;
		logic [31:0] rdata;
		logic grant;
		logic deny;
		logic [15:0] deny_cnt;
		logic [2:0] last_mode;
		logic [2:0] last_kind;
	} cmg_state_t;

	cmg_state_t st;
	cmg_state_t next_st;
	logic [cmg_pkg::RG_W-1:0] region;
	logic addr_phase;
	logic [7:0] ofs;
	logic is_sys;
	logic [19:0] ram_off;
	logic [15:0] win_base;
	logic [16:0] win_end;
	logic in_win;
	logic allow;

	// Fixed partition lookup
	cmg_region_dec u_region (
		.addr(acc_addr),
		.region(region)
	);

	// Address phase qualification
	assign addr_phase = hsel && htrans[1] && hready;
	assign ofs = haddr[7:0];
	assign is_sys = (bus_mode == cmg_pkg::MODE_SYS);

	// Firmware RAM window bounds
	assign win_base = {st.win_bh, st.win_bl};
	assign win_end = {1'b0, win_base} + {1'b0, st.win_sh, st.win_sl};
	assign ram_off = acc_addr - cmg_pkg::APP_RAM_LO;
	assign in_win = (ram_off >= {4'h0, win_base}) && (ram_off < {3'h0, win_end});

	// Permission decision per mode and region
	always_comb begin
		allow = 1'b0;
		unique case (acc_mode)
			cmg_pkg::MODE_BOOT, cmg_pkg::MODE_TEST: begin
				allow = |region;
			end
			cmg_pkg::MODE_FW: begin
				if (acc_emul) begin
					// Emulation firmware only in its own area
					allow = region[cmg_pkg::RG_FW_EE];
				end else if (acc_integrity && (region[cmg_pkg::RG_APP_EE] || region[cmg_pkg::RG_FW_EE])) begin
					allow = !acc_kind[cmg_pkg::KIND_X];
				end else if (region[cmg_pkg::RG_FW_ROM]) begin
					allow = !acc_kind[cmg_pkg::KIND_W];
				end else if (region[cmg_pkg::RG_FW_EE] || region[cmg_pkg::RG_FW_RAM]) begin
					allow = !(region[cmg_pkg::RG_FW_RAM] && acc_kind[cmg_pkg::KIND_X]);
				end else if (region[cmg_pkg::RG_APP_RAM]) begin
					allow = in_win && !acc_kind[cmg_pkg::KIND_X];
				end
			end
			cmg_pkg::MODE_SYS: begin
				if (region[cmg_pkg::RG_APP_ROM]) begin
					allow = !acc_kind[cmg_pkg::KIND_W];
				end else if (region[cmg_pkg::RG_APP_EE]) begin
					allow = 1'b1;
				end else if (region[cmg_pkg::RG_APP_RAM]) begin
					allow = !acc_kind[cmg_pkg::KIND_X];
				end
			end
			cmg_pkg::MODE_USER: begin
				// Zero base disables all segments
				if (st.seg_base != cmg_pkg::SEG_BASE_RST) begin
					if (region[cmg_pkg::RG_APP_ROM] || region[cmg_pkg::RG_APP_EE] || region[cmg_pkg::RG_APP_RAM]) begin
						allow = ((acc_kind & acc_seg_rights) == acc_kind) && (acc_kind != 3'h0);
						if (region[cmg_pkg::RG_APP_ROM] && acc_kind[cmg_pkg::KIND_W]) begin
							allow = 1'b0;
						end
						if (region[cmg_pkg::RG_APP_RAM] && acc_kind[cmg_pkg::KIND_X]) begin
							allow = 1'b0;
						end
					end
				end
			end
			default: begin
				allow = 1'b0;
			end
		endcase
	end

	// Next state: bus slave, registers and decision
	always_comb begin
		next_st = st;
		next_st.grant = 1'b0;
		next_st.deny = 1'b0;
		// Data phase write, only from system mode
		next_st.wr_pend = 1'b0;
		if (st.wr_pend && st.wr_sys) begin
			unique case (st.wr_ofs)
				cmg_pkg::OFS_SEG_BASE: next_st.seg_base = hwdata[15:0];
				cmg_pkg::OFS_WIN_BL: next_st.win_bl = hwdata[7:0];
				cmg_pkg::OFS_WIN_BH: next_st.win_bh = hwdata[7:0];
				cmg_pkg::OFS_WIN_SL: next_st.win_sl = hwdata[7:0];
				cmg_pkg::OFS_WIN_SH: next_st.win_sh = hwdata[7:0];
				default: next_st.seg_base = st.seg_base;
			endcase
		end
		// Address phase capture
		if (addr_phase) begin
			next_st.wr_pend = hwrite;
			next_st.wr_ofs = ofs;
			next_st.wr_sys = is_sys;
			next_st.rdata = 32'h00000000;
			if (!hwrite) begin
				if (ofs == cmg_pkg::OFS_STATUS) begin
					next_st.rdata = {st.deny_cnt, 10'h000, st.last_kind, st.last_mode};
				end else if (is_sys) begin
					unique case (ofs)
						cmg_pkg::OFS_SEG_BASE: next_st.rdata = {16'h0000, st.seg_base};
						cmg_pkg::OFS_WIN_BL: next_st.rdata = {24'h000000, st.win_bl};
						cmg_pkg::OFS_WIN_BH: next_st.rdata = {24'h000000, st.win_bh};
						cmg_pkg::OFS_WIN_SL: next_st.rdata = {24'h000000, st.win_sl};
						cmg_pkg::OFS_WIN_SH: next_st.rdata = {24'h000000, st.win_sh};
						default: next_st.rdata = 32'h00000000;
					endcase
				end
			end
		end
		// Core access decision and deny record
		if (acc_valid) begin
			next_st.grant = allow;
			next_st.deny = !allow;
			if (!allow) begin
				next_st.deny_cnt = st.deny_cnt + 16'h0001;
				next_st.last_mode = acc_mode;
				next_st.last_kind = acc_kind;
			end
		end
	end

	// State register with restrictive reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st.seg_base <= cmg_pkg::SEG_BASE_RST;
			st.win_bl <= cmg_pkg::WIN_RST;
			st.win_bh <= cmg_pkg::WIN_RST;
			st.win_sl <= cmg_pkg::WIN_RST;
			st.win_sh <= cmg_pkg::WIN_RST;
			st.wr_pend <= 1'b0;
			st.wr_ofs <= 8'h00;
			st.wr_sys <= 1'b0;
			st.rdata <= 32'h00000000;
			st.grant <= 1'b0;
			st.deny <= 1'b0;
			st.deny_cnt <= cmg_pkg::CNT_RST;
			st.last_mode <= 3'h0;
			st.last_kind <= 3'h0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs; slave never stalls and always answers OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;
	assign acc_grant = st.grant;
	assign acc_deny = st.deny;
	assign seg_table_base = st.seg_base;

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Write and read address phases on the config port
	sequence wr_addr_s(logic [7:0] o, logic sys);
		addr_phase && hwrite && ofs == o && is_sys == sys;
	endsequence

	sequence rd_addr_s(logic [7:0] o, logic sys);
		addr_phase && !hwrite && ofs == o && is_sys == sys;
	endsequence

	// One core request in a given mode
	sequence acc_req_s(logic [2:0] m);
		acc_valid && acc_mode == m;
	endsequence

	// Reset defaults and config register protection
	base_reset_zero_a: assert property ($rose(hresetn) |-> seg_table_base == 16'h0000)
		else $error("segment base not zero after reset");
	user_no_base_a: assert property (
		acc_valid && acc_mode == cmg_pkg::MODE_USER && seg_table_base == 16'h0000 |=> acc_deny && !acc_grant)
		else $error("user access granted with zero base");
	cfg_user_block_a: assert property (wr_addr_s(cmg_pkg::OFS_SEG_BASE, 1'b0) |=> ##1 $stable(seg_table_base))
		else $error("non-system write changed segment base");
	cfg_sys_write_a: assert property (wr_addr_s(cmg_pkg::OFS_SEG_BASE, 1'b1) ##1 1'b1
		|=> seg_table_base == $past(hwdata[15:0]))
		else $error("system write did not load segment base");
	win_fw_block_a: assert property (wr_addr_s(cmg_pkg::OFS_WIN_BL, 1'b0) |=> ##1 $stable(st.win_bl))
		else $error("firmware changed exchange window");
	win_sys_write_a: assert property (wr_addr_s(cmg_pkg::OFS_WIN_BH, 1'b1) ##1 1'b1
		|=> st.win_bh == $past(hwdata[7:0]))
		else $error("system write did not load window base");
	cfg_user_read_a: assert property (rd_addr_s(cmg_pkg::OFS_SEG_BASE, 1'b0)
		|=> hrdata == 32'h00000000)
		else $error("segment base visible outside system mode");
	cfg_sys_read_a: assert property (rd_addr_s(cmg_pkg::OFS_SEG_BASE, 1'b1)
		|=> hrdata[15:0] == $past(seg_table_base))
		else $error("system read of segment base wrong");
	status_ro_a: assert property (wr_addr_s(cmg_pkg::OFS_STATUS, 1'b1) |=> ##1
		$stable({st.seg_base, st.win_bl, st.win_bh, st.win_sl, st.win_sh}))
		else $error("status write changed a register");
	// Base only moves through a landing system write
	base_hold_a: assert property (
		!(st.wr_pend && st.wr_sys && st.wr_ofs == cmg_pkg::OFS_SEG_BASE) |=> $stable(seg_table_base))
		else $error("segment base moved without system write");
	// Read data stands until the next address phase
	hrdata_hold_a: assert property (!addr_phase |=> $stable(hrdata))
		else $error("read data changed outside address phase");

	// Firmware partition and firewall
	fw_window_a: assert property (
		acc_valid && acc_mode == cmg_pkg::MODE_FW && !acc_emul && !acc_integrity
		&& region[cmg_pkg::RG_APP_RAM] && !in_win |=> acc_deny)
		else $error("firmware reached RAM outside window");
	win_grant_a: assert property (acc_req_s(cmg_pkg::MODE_FW) ##0
		(!acc_emul && region[cmg_pkg::RG_APP_RAM] && in_win && !acc_kind[cmg_pkg::KIND_X]) |=> acc_grant)
		else $error("firmware refused inside window");
	emul_confine_a: assert property (
		acc_valid && acc_mode == cmg_pkg::MODE_FW && acc_emul
		&& !region[cmg_pkg::RG_FW_EE] |=> acc_deny)
		else $error("emulation firmware left its area");
	emul_own_a: assert property (acc_req_s(cmg_pkg::MODE_FW) ##0
		(acc_emul && region[cmg_pkg::RG_FW_EE]) |=> acc_grant)
		else $error("emulation firmware refused its own area");
	integ_ee_a: assert property (
		acc_valid && acc_mode == cmg_pkg::MODE_FW && !acc_emul && acc_integrity
		&& region[cmg_pkg::RG_APP_EE] && acc_kind == 3'h2 |=> acc_grant)
		else $error("integrity write to EEPROM refused");
	integ_no_exec_a: assert property (acc_req_s(cmg_pkg::MODE_FW) ##0
		(!acc_emul && acc_integrity && region[cmg_pkg::RG_APP_EE] && acc_kind[cmg_pkg::KIND_X]) |=> acc_deny)
		else $error("integrity function executed from EEPROM");
	fw_app_rom_a: assert property (
		acc_valid && acc_mode == cmg_pkg::MODE_FW
		&& region[cmg_pkg::RG_APP_ROM] |=> acc_deny)
		else $error("firmware reached application ROM");
	fw_app_ee_a: assert property (acc_req_s(cmg_pkg::MODE_FW) ##0
		(!acc_emul && !acc_integrity && region[cmg_pkg::RG_APP_EE]) |=> acc_deny)
		else $error("firmware reached application EEPROM");
	fw_rom_write_a: assert property (acc_req_s(cmg_pkg::MODE_FW) ##0
		(region[cmg_pkg::RG_FW_ROM] && acc_kind[cmg_pkg::KIND_W]) |=> acc_deny)
		else $error("firmware wrote its ROM");

	// System and user code stay out of firmware areas
	sys_fw_area_a: assert property (acc_req_s(cmg_pkg::MODE_SYS) ##0
		(region[cmg_pkg::RG_FW_ROM] || region[cmg_pkg::RG_FW_EE] || region[cmg_pkg::RG_FW_RAM]) |=> acc_deny)
		else $error("system code reached a firmware area");
	sys_ram_exec_a: assert property (acc_req_s(cmg_pkg::MODE_SYS) ##0
		(region[cmg_pkg::RG_APP_RAM] && acc_kind[cmg_pkg::KIND_X]) |=> acc_deny)
		else $error("system code ran from RAM");
	user_fw_area_a: assert property (acc_req_s(cmg_pkg::MODE_USER) ##0
		(region[cmg_pkg::RG_FW_ROM] || region[cmg_pkg::RG_FW_EE] || region[cmg_pkg::RG_FW_RAM]) |=> acc_deny)
		else $error("user code reached a firmware area");

	// User rights follow the covering segment
	user_rights_a: assert property (
		acc_valid && acc_mode == cmg_pkg::MODE_USER && acc_kind[cmg_pkg::KIND_W]
		&& !acc_seg_rights[cmg_pkg::KIND_W] |=> acc_deny)
		else $error("user write without segment write right");
	user_write_ok_a: assert property (acc_req_s(cmg_pkg::MODE_USER) ##0
		(seg_table_base != 16'h0000 && region[cmg_pkg::RG_APP_EE] && acc_kind == 3'h2
		&& acc_seg_rights[cmg_pkg::KIND_W]) |=> acc_grant)
		else $error("user write refused despite write right");
	user_ram_exec_a: assert property (acc_req_s(cmg_pkg::MODE_USER) ##0
		(region[cmg_pkg::RG_APP_RAM] && acc_kind[cmg_pkg::KIND_X]) |=> acc_deny)
		else $error("user code ran from RAM");
	user_rom_write_a: assert property (acc_req_s(cmg_pkg::MODE_USER) ##0
		(region[cmg_pkg::RG_APP_ROM] && acc_kind[cmg_pkg::KIND_W]) |=> acc_deny)
		else $error("user code wrote ROM");

	// Boot reaches every mapped area, nobody reaches the unmapped ones
	boot_mapped_a: assert property (acc_req_s(cmg_pkg::MODE_BOOT) ##0 (region != '0) |=> acc_grant)
		else $error("boot refused a mapped address");
	unmapped_deny_a: assert property (acc_valid && region == '0 |=> acc_deny)
		else $error("unmapped address granted");

	// Answer pulses and deny record
	one_answer_a: assert property (acc_valid |=> acc_grant != acc_deny)
		else $error("request not answered exactly once");
	no_spur_ans_a: assert property (!acc_valid |=> !acc_grant && !acc_deny)
		else $error("answer without a request");
	deny_record_a: assert property (acc_valid && !allow
		|=> st.last_mode == $past(acc_mode) && st.last_kind == $past(acc_kind))
		else $error("deny record lost mode or kind");
	deny_count_a: assert property (
		acc_valid && !allow && st.deny_cnt != 16'hffff
		|=> acc_deny && st.deny_cnt == $past(st.deny_cnt) + 16'h0001 && !acc_grant)
		else $error("deny not recorded or grant raised");
endmodule
`default_nettype wire

/* File: hdl/cmg_pkg.sv */
// Purpose: Constants for the mode-based memory access guard
// Assumes: 20-bit core address space, AHB-Lite register port
// Notes: Memory partition bounds are fixed constants only
package cmg_pkg;
	// CPU modes as supplied by the core
	localparam logic [2:0] MODE_BOOT = 3'h0;
	localparam logic [2:0] MODE_TEST = 3'h1;
	localparam logic [2:0] MODE_FW = 3'h2;
	localparam logic [2:0] MODE_SYS = 3'h3;
	localparam logic [2:0] MODE_USER = 3'h4;
	// Access kind bits
	localparam int KIND_R = 0;
	localparam int KIND_W = 1;
	localparam int KIND_X = 2;
	// Fixed memory partition, no register can move it
	localparam logic [19:0] APP_ROM_LO = 20'h00000;
	localparam logic [19:0] FW_ROM_LO = 20'h30000;
	localparam logic [19:0] APP_EE_LO = 20'h40000;
	localparam logic [19:0] FW_EE_LO = 20'h70000;
	localparam logic [19:0] APP_RAM_LO = 20'h80000;
	localparam logic [19:0] FW_RAM_LO = 20'h8c000;
	localparam logic [19:0] MEM_END = 20'h90000;
	// Region one-hot bit positions
	localparam int RG_APP_ROM = 0;
	localparam int RG_FW_ROM = 1;
	localparam int RG_APP_EE = 2;
	localparam int RG_FW_EE = 3;
	localparam int RG_APP_RAM = 4;
	localparam int RG_FW_RAM = 5;
	localparam int RG_W = 6;
	// Register byte offsets
	localparam logic [7:0] OFS_SEG_BASE = 8'h00;
	localparam logic [7:0] OFS_WIN_BL = 8'h04;
	localparam logic [7:0] OFS_WIN_BH = 8'h08;
	localparam logic [7:0] OFS_WIN_SL = 8'h0c;
	localparam logic [7:0] OFS_WIN_SH = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// Restrictive reset values
	localparam logic [15:0] SEG_BASE_RST = 16'h0000;
	localparam logic [7:0] WIN_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
endpackage

/* File: hdl/cmg_region_dec.sv */
// Purpose: Classify a core address into one fixed memory region
// Assumes: Partition bounds from cmg_pkg, ascending order
// Notes: Addresses at or above the end hit no region
`timescale 1ns/1ps
`default_nettype none
module cmg_region_dec (
	input wire logic [19:0] addr,
	output logic [cmg_pkg::RG_W-1:0] region
);
	// Bound compare against the fixed partition
	always_comb begin
		region = '0;
		if (addr < cmg_pkg::FW_ROM_LO) begin
			region[cmg_pkg::RG_APP_ROM] = 1'b1;
		end else if (addr < cmg_pkg::APP_EE_LO) begin
			region[cmg_pkg::RG_FW_ROM] = 1'b1;
		end else if (addr < cmg_pkg::FW_EE_LO) begin
			region[cmg_pkg::RG_APP_EE] = 1'b1;
		end else if (addr < cmg_pkg::APP_RAM_LO) begin
			region[cmg_pkg::RG_FW_EE] = 1'b1;
		end else if (addr < cmg_pkg::FW_RAM_LO) begin
			region[cmg_pkg::RG_APP_RAM] = 1'b1;
		end else if (addr < cmg_pkg::MEM_END) begin
			region[cmg_pkg::RG_FW_RAM] = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verif/cmg_core_model.sv */
// Purpose: Core model issuing mode-tagged accesses
// Assumes: Bench hands over one request per go cycle
// Notes: Idle fields show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module cmg_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [30:0] req,
	output logic acc_valid,
	output logic [2:0] acc_mode,
	output logic [19:0] acc_addr,
	output logic [2:0] acc_kind,
	output logic acc_integrity,
	output logic acc_emul,
	output logic [2:0] acc_seg_rights
);
	// One access per go cycle, scrambled fields while idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_valid <= 1'b0;
			{acc_mode, acc_addr, acc_kind, acc_integrity, acc_emul, acc_seg_rights} <= '0;
		end else begin
			acc_valid <= go;
			{acc_mode, acc_addr, acc_kind, acc_integrity, acc_emul, acc_seg_rights} <= go ? req :
				~{acc_mode, acc_addr, acc_kind, acc_integrity, acc_emul, acc_seg_rights};
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb_cpu_mode_memory_access_guard.sv */
// Purpose: Self-checking bench for the mode-based access guard
// Assumes: Single slave, so hready follows hreadyout
// Notes: Access decisions checked against an integer model
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_mode_memory_access_guard;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r, v;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2, bus_mode = '0, acc_mode, acc_kind, acc_seg_rights;
	logic [30:0] rq = '0;
	logic [19:0] acc_addr;
	logic [15:0] seg_table_base;
	logic hready, hreadyout, hresp, acc_valid, acc_integrity, acc_emul, acc_grant, acc_deny;
	int n_errors = 0, compares = 0, nd = 0, lm = 0, lk = 0, rg[5] = '{default: 0};
	bit [7:0] q[$];
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	cmg_core_model core (.hclk(hclk), .hresetn(hresetn), .go(go), .req(rq), .acc_valid(acc_valid),
		.acc_mode(acc_mode), .acc_addr(acc_addr), .acc_kind(acc_kind), .acc_integrity(acc_integrity),
		.acc_emul(acc_emul), .acc_seg_rights(acc_seg_rights));
	cmg_guard DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .bus_mode(bus_mode), .acc_valid(acc_valid), .acc_mode(acc_mode),
		.acc_addr(acc_addr), .acc_kind(acc_kind), .acc_integrity(acc_integrity), .acc_emul(acc_emul),
		.acc_seg_rights(acc_seg_rights), .acc_grant(acc_grant), .acc_deny(acc_deny),
		.seg_table_base(seg_table_base));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One AHB-Lite single word transfer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] m);
		@(posedge hclk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; bus_mode <= m;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		chk(hresp, 0);
	endtask
	// Read back every offset and status against the model
	task automatic rd_all(input logic [2:0] m);
		for (int a = 0; a <= 24; a += 4) begin
			bus(1'b0, a[7:0], 32'h0, m);
			if (a == 20) chk(r, {nd[15:0], 10'h000, lk[2:0], lm[2:0]});
			else chk(r, (a < 20 && m == 3'h3) ? rg[a / 4] : 0);
		end
	endtask
	// Expected decision
	function automatic bit ok(int m, int a, int k, int ig, int em, int rt);
		int al, am, wb, ws;
		wb = rg[1] + rg[2] * 256;
		ws = rg[3] + rg[4] * 256;
		am = a < 'h30000 ? 5 : (a >= 'h40000 && a < 'h70000) ? 7 : (a >= 'h80000 && a < 'h8c000) ? 3 : 0;
		al = 0;
		if (a >= 'h90000 || m > 4) return 0;
		if (m < 2) return 1;
		if (m == 3) al = am;
		if (m == 4 && rg[0] != 0) al = am & rt;
		if (m == 2 && em != 0) return a >= 'h70000 && a < 'h80000;
		if (m == 2) begin
			if (a >= 'h30000 && a < 'h40000) al = 5;
			if (ig != 0 && a >= 'h40000 && a < 'h80000) al = 3;
			else if (a >= 'h70000 && a < 'h80000) al = 7;
			if (a >= 'h8c000 || (a >= 'h80000 + wb && a < 'h80000 + wb + ws && a < 'h8c000)) al = 3;
		end
		return (k & ~al) == 0;
	endfunction
	// Random accesses with window edge probes every eighth cycle
	task automatic stream(input int n);
		int m, a, k, ig, em, rt;
		bit [7:0] p;
		q.delete();
		for (int i = 0; i < n + 2; i++) begin
			m = $urandom % 5; a = $urandom % 'h92000; k = 1 + $urandom % 7;
			ig = $urandom % 4 == 0; em = $urandom % 4 == 0; rt = $urandom % 8;
			if (i % 8 == 7) begin
				m = 2; k = 1; em = 0;
				a = 'h80000 + rg[1] + rg[2] * 256 + rg[3] + rg[4] * 256 - (i / 8) % 2;
			end
			@(posedge hclk);
			go <= i < n;
			rq <= {m[2:0], a[19:0], k[2:0], ig[0], em[0], rt[2:0]};
			q.push_back({m[2:0], k[2:0], i < n, ok(m, a, k, ig, em, rt)});
			@(negedge hclk);
			if (q.size() == 3) begin
				p = q.pop_front();
				chk(acc_grant, p[1] & p[0]);
				chk(acc_deny, p[1] & !p[0]);
				if (p[1] & !p[0]) begin
					nd++;
					lm = p[7:5];
					lk = p[4:2];
				end
			end
		end
	endtask
	initial begin
		#(25 * 8000);
		n_errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'he8f57567));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk(seg_table_base, 0);
		rd_all(3'h3);
		stream(150);
		for (int m = 0; m < 5; m++) begin
			v = $urandom | 1;
			bus(1'b1, 8'h00, v, m[2:0]);
			if (m == 3) rg[0] = v[15:0];
		end
		for (int m = 2; m < 4; m++) begin
			for (int j = 1; j < 5; j++) begin
				v = $urandom % (j == 4 ? 64 : j == 2 ? 128 : 256);
				bus(1'b1, 8'(j * 4), v, m[2:0]);
				if (m == 3) rg[j] = v[7:0];
			end
		end
		bus(1'b1, 8'h14, 32'hffffffff, 3'h3);
		rd_all(3'h3);
		rd_all(3'h4);
		chk(seg_table_base, rg[0]);
		stream(500);
		rd_all(3'h3);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rg = '{default: 0};
		nd = 0;
		lm = 0;
		lk = 0;
		@(negedge hclk);
		chk(seg_table_base, 0);
		rd_all(3'h3);
		stream(40);
		wrap_up();
	end
endmodule
`default_nettype wire
